// File: hw/ptw_decode.sv
// PCI inbound target window decoder with AXI4-Lite configuration slave.
// Assumes a PCI front end presents one address per cycle as a valid pulse and takes claim on the next cycle.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ptw_defines.svh"
module ptw_decode (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output logic s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire s_axi_rready,
    input wire ptw_pkg::ptw_req_t pci_req,
    output ptw_pkg::ptw_rsp_t pci_rsp
);
    // ------------------------------------------------------------
    // Window settings
    // ------------------------------------------------------------
    ptw_pkg::ptw_win_t win_ff [`PTW_NUM_WIN];
    logic w4_en_ff;
    logic [31:0] claim_cnt_ff;

    // ------------------------------------------------------------
    // AXI write channel
    // ------------------------------------------------------------
    logic aw_got_ff, w_got_ff;
    logic [11:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_got_ff && w_got_ff;
    wire [1:0] wr_win = awaddr_ff[5:4];
    wire [11:0] wr_reg = {8'h00, awaddr_ff[3:0]};
    wire wr_in_win = awaddr_ff[11:6] == 6'h00 && awaddr_ff[1:0] == 2'h0;
    wire wr_ctrl = awaddr_ff == `PTW_OFS_CTRL;
    wire wr_ok = wr_in_win || wr_ctrl || awaddr_ff == `PTW_OFS_STAT;
    wire [31:0] wr_data = wdata_ff;
    wire wr_lane0 = wstrb_ff[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= `PTW_RST_WORD;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PTW_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= wr_ok ? `PTW_RESP_OKAY : `PTW_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Register writes honour byte lanes only as a whole word; lane 0 must be set.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < `PTW_NUM_WIN; i++) begin
                win_ff[i] <= '0;
            end
            w4_en_ff <= 1'b0;
        end else if (wr_go && wr_lane0) begin
            if (wr_in_win) begin
                unique case (wr_reg)
                    `PTW_OFS_BASE: begin
                        win_ff[wr_win].en <= wr_data[`PTW_BIT_EN];
                        win_ff[wr_win].sg <= wr_data[`PTW_BIT_SG];
                        win_ff[wr_win].dac_en <= (wr_win == 2'h3) && wr_data[`PTW_BIT_DAC];
                        win_ff[wr_win].base <= wr_data[31:20];
                    end
                    `PTW_OFS_MASK: win_ff[wr_win].mask <= wr_data[31:20];
                    `PTW_OFS_TBASE: win_ff[wr_win].tbase <= wr_data[31:18];
                    `PTW_OFS_DAC: begin
                        if (wr_win == 2'h3) begin
                            win_ff[3].dac <= wr_data[7:0];
                        end
                    end
                    default: ;
                endcase
            end else if (wr_ctrl) begin
                w4_en_ff <= wr_data[`PTW_BIT_W4EN];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI read channel
    // ------------------------------------------------------------
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    wire [1:0] rd_win = s_axi_araddr[5:4];
    wire rd_in_win = s_axi_araddr[11:6] == 6'h00 && s_axi_araddr[1:0] == 2'h0;
    ptw_pkg::ptw_win_t rd_cfg;
    assign rd_cfg = win_ff[rd_win];
    wire [31:0] rd_base = {rd_cfg.base, 17'h0, rd_cfg.dac_en, rd_cfg.sg, rd_cfg.en};
    wire [31:0] rd_mask = {rd_cfg.mask, 20'h0_0000};
    wire [31:0] rd_tbase = {rd_cfg.tbase, 18'h0};
    wire [31:0] rd_dac = {24'h00_0000, rd_cfg.dac};
    wire [31:0] rd_win_word = s_axi_araddr[3:2] == 2'h0 ? rd_base :
                              s_axi_araddr[3:2] == 2'h1 ? rd_mask :
                              s_axi_araddr[3:2] == 2'h2 ? rd_tbase : rd_dac;
    wire rd_ctrl = s_axi_araddr == `PTW_OFS_CTRL;
    wire rd_stat = s_axi_araddr == `PTW_OFS_STAT;
    wire rd_ok = rd_in_win || rd_ctrl || rd_stat;
    wire [31:0] rd_word = rd_in_win ? rd_win_word :
                          rd_ctrl ? {31'h0, w4_en_ff} :
                          rd_stat ? claim_cnt_ff : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= `PTW_RST_WORD;
            rresp_ff <= `PTW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_ok ? `PTW_RESP_OKAY : `PTW_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Window compare
    // ------------------------------------------------------------
    logic [`PTW_NUM_WIN-1:0] hit_vec;
    logic [33:0] win_addr [`PTW_NUM_WIN];
    genvar g;
    generate
        for (g = 0; g < `PTW_NUM_WIN; g++) begin : g_win
            ptw_win_cmp #(.HAS_DAC(g == 3)) u_cmp (
                .cfg(win_ff[g]),
                .req(pci_req),
                .hit(hit_vec[g]),
                .maddr(win_addr[g])
            );
        end
    endgenerate

    // Window 4 takes only DAC cycles inside the low 16GB and maps them one to one.
    wire w4_hit = pci_req.valid && pci_req.dac && w4_en_ff && pci_req.addr[63:34] == 30'h0;
    wire any_hit = (|hit_vec) || w4_hit;

    logic [2:0] sel_win;
    logic [33:0] sel_addr;
    always_comb begin
        sel_win = 3'h4;
        sel_addr = pci_req.addr[33:0];
        for (int i = `PTW_NUM_WIN - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                sel_win = 3'(i);
                sel_addr = win_addr[i];
            end
        end
    end

    // Memory lies in the low 16GB; bit 33 is passed through, from the translated base for windows 3..0 and from the PCI address for window 4.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pci_rsp <= '0;
            claim_cnt_ff <= 32'h0000_0000;
        end else begin
            pci_rsp.claim <= any_hit;
            pci_rsp.win <= any_hit ? sel_win : 3'h0;
            pci_rsp.sg <= any_hit && sel_win != 3'h4 && win_ff[sel_win[1:0]].sg;
            pci_rsp.maddr <= any_hit ? sel_addr : 34'h0_0000_0000;
            if (any_hit) begin
                claim_cnt_ff <= claim_cnt_ff + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_claim_on_hit: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac == 1'b0 && win_ff[2].en && win_ff[2].mask == 12'hfff) |=> pci_rsp.claim)
        else $error("enabled full window did not claim");
    a_no_claim_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pci_req.valid) |=> !pci_rsp.claim)
        else $error("claim without request");
    a_disabled_miss: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && !pci_req.dac && !win_ff[0].en && !win_ff[1].en && !win_ff[2].en && !win_ff[3].en)
        |=> !pci_rsp.claim)
        else $error("disabled windows claimed");
    a_dac_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && pci_req.addr[63:40] != 24'h00_0000) |=> !pci_rsp.claim)
        else $error("dac with high bits claimed");
    a_w4_direct: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && hit_vec == 4'h0 && w4_hit) |=>
        (pci_rsp.win == 3'h4 && pci_rsp.maddr == $past(pci_req.addr[33:0])))
        else $error("window 4 not direct");
    a_sac_no_w4: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && !pci_req.dac) |=> pci_rsp.win != 3'h4)
        else $error("single cycle hit window 4");
    a_direct_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_vec[0] && !win_ff[0].sg && win_ff[0].mask == 12'h000) |=>
        (pci_rsp.maddr[19:0] == $past(pci_req.addr[19:0])))
        else $error("direct low bits wrong");
    a_dac_w3_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac) |-> (hit_vec[2:0] == 3'h0))
        else $error("low window hit on dac");
    a_sg_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_vec[2] && win_ff[2].sg && hit_vec[1:0] == 2'h0) |=> pci_rsp.sg)
        else $error("sg flag lost");

    // ------------------------------------------------------------
    // Decode and translation checks
    // ------------------------------------------------------------
    // These tie each answer back to the window settings and to the compare stage hit vector.
    a_miss_no_claim: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && hit_vec == 4'h0 && !w4_hit) |=> !pci_rsp.claim)
        else $error("claim without any window hit");
    a_hit_claims: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && hit_vec != 4'h0) |=> (pci_rsp.claim && pci_rsp.win != 3'h4))
        else $error("window hit not claimed");
    a_w4_off: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && !w4_en_ff && !hit_vec[3]) |=> !pci_rsp.claim)
        else $error("disabled window 4 claimed");
    a_w4_claims: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && hit_vec == 4'h0 && w4_en_ff && pci_req.addr[63:34] == 30'h0)
        |=> (pci_rsp.claim && pci_rsp.win == 3'h4))
        else $error("window 4 cycle not claimed");
    a_w3_dac_match: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && win_ff[3].en && win_ff[3].dac_en && win_ff[3].mask == 12'h000
        && pci_req.addr[63:40] == 24'h00_0000 && pci_req.addr[39:32] == win_ff[3].dac
        && pci_req.addr[31:20] == win_ff[3].base) |=> (pci_rsp.claim && pci_rsp.win == 3'h3))
        else $error("dac hit on window 3 lost");
    a_dac_base_miss: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && pci_req.dac && pci_req.addr[39:32] != win_ff[3].dac && !w4_hit) |=> !pci_rsp.claim)
        else $error("dac base mismatch claimed");
    a_direct_tbase: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_vec[0] && !win_ff[0].sg && win_ff[0].mask == 12'h000) |=>
        (pci_rsp.maddr[33:20] == $past(win_ff[0].tbase)))
        else $error("direct high bits not from translated base");
    a_sg_entry: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_vec[2] && win_ff[2].sg && win_ff[2].mask == 12'hfff && hit_vec[1:0] == 2'h0) |=>
        (pci_rsp.maddr[21:0] == {$past(pci_req.addr[31:13]), 3'h0}))
        else $error("table entry address wrong");
    a_mask_inside: assert property (@(posedge aclk) disable iff (!aresetn)
        (pci_req.valid && !pci_req.dac && win_ff[1].en && win_ff[1].mask == 12'h00f
        && pci_req.addr[31:24] == win_ff[1].base[11:4]) |-> hit_vec[1])
        else $error("address inside window missed");
    a_mask_outside: assert property (@(posedge aclk) disable iff (!aresetn)
        (win_ff[1].mask == 12'h00f && pci_req.addr[31:24] != win_ff[1].base[11:4]) |-> !hit_vec[1])
        else $error("address outside window hit");
    a_en_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (!win_ff[0].en) |-> !hit_vec[0])
        else $error("disabled window 0 hit");
    a_claim_count: assert property (@(posedge aclk) disable iff (!aresetn)
        any_hit |=> claim_cnt_ff == $past(claim_cnt_ff) + 32'h0000_0001)
        else $error("claim count not advanced");
    a_count_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !any_hit |=> $stable(claim_cnt_ff))
        else $error("claim count moved without a claim");
    a_sg_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        (hit_vec[0] && !win_ff[0].sg) |=> !pci_rsp.sg)
        else $error("direct window flagged as table lookup");
    a_idle_rsp_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (!pci_req.valid) |=> (pci_rsp.maddr == 34'h0_0000_0000 && pci_rsp.win == 3'h0))
        else $error("idle answer not cleared");
endmodule : ptw_decode

// File: hw/ptw_defines.svh
// Constants for the PCI target window decoder: register offsets, field positions, reset values.
// Assumes inclusion by bare name from ptw_decode; the package and ptw_win_cmp do not include it.
//
// Summary of operation
// - Five independently programmable target windows.
// - Hits map into 16GB cached memory space.
// - Window 4 maps dual-address cycles straight through.
// - Windows 3..0 have base, mask, translated base.
// - Window 3 adds a DAC base setting.
// - Mask covers bits 31..20, sizes 1MB-4GB.
// - Mask is ones from bit 20 upward.
// - Compare only bits 31..n; n=32 always hits.
// - Base enable bit gates each window; window 4 is gated by CTRL bit 0 instead.
// - Any enabled hit claims the cycle.
// - No base/limit; whole window responds.
// - Each window picks direct or scatter-gather; window 4 is always direct.
// - Upper-bit compare only window 3, DAC-enabled.
// - DAC hit: 63..40 zero, 39..32 match.
// - Hit yields a 34-bit memory address.
// - Direct: translated base OR unmasked low bits.
// - Scatter-gather: table address from translated base.
`ifndef PTW_DEFINES_SVH
`define PTW_DEFINES_SVH

`define PTW_NUM_WIN 4
`define PTW_WIN_STRIDE 12'h010
`define PTW_OFS_BASE 12'h000
`define PTW_OFS_MASK 12'h004
`define PTW_OFS_TBASE 12'h008
`define PTW_OFS_DAC 12'h00c
`define PTW_OFS_CTRL 12'h040
`define PTW_OFS_STAT 12'h044
`define PTW_BIT_EN 0
`define PTW_BIT_SG 1
`define PTW_BIT_DAC 2
`define PTW_BIT_W4EN 0
`define PTW_RST_WORD 32'h0000_0000
`define PTW_RESP_OKAY 2'h0
`define PTW_RESP_SLVERR 2'h2

`endif

// File: hw/ptw_pkg.sv
// Types shared by the PCI target window decoder.
// Assumes ptw_defines.svh is on the include path.
package ptw_pkg;
    typedef struct packed {
        logic        valid;
        logic        dac;
        logic [63:0] addr;
    } ptw_req_t;

    typedef struct packed {
        logic        claim;
        logic        sg;
        logic [2:0]  win;
        logic [33:0] maddr;
    } ptw_rsp_t;

    typedef struct packed {
        logic        en;
        logic        sg;
        logic        dac_en;
        logic [11:0] base;
        logic [11:0] mask;
        logic [13:0] tbase;
        logic [7:0]  dac;
    } ptw_win_t;
endpackage : ptw_pkg

// File: hw/ptw_win_cmp.sv
// One target window compare and translate stage for windows 3..0.
// Assumes the mask is a run of ones from bit 20 and software aligns bases.
`timescale 1ns/1ns
module ptw_win_cmp #(
    parameter bit HAS_DAC = 1'b0
) (
    input wire ptw_pkg::ptw_win_t cfg,
    input wire ptw_pkg::ptw_req_t req,
    output logic hit,
    output logic [33:0] maddr
);
    // ------------------------------------------------------------
    // Masked compare
    // ------------------------------------------------------------
    wire [11:0] cmp_mask = ~cfg.mask;
    wire low_hit = ((req.addr[31:20] ^ cfg.base) & cmp_mask) == 12'h000;
    wire dac_ok = HAS_DAC && cfg.dac_en && (req.addr[63:40] == 24'h00_0000)
        && (req.addr[39:32] == cfg.dac);
    wire space_ok = req.dac ? dac_ok : 1'b1;
    assign hit = req.valid && cfg.en && low_hit && space_ok;

    // ------------------------------------------------------------
    // Translation
    // ------------------------------------------------------------
    // Direct: translated base bits above n, PCI bits below n.
    wire [33:0] keep = {2'h0, cfg.mask, 20'hf_ffff};
    wire [33:0] dir_addr = ({cfg.tbase, 20'h0_0000} & ~keep) | ({2'h0, req.addr[31:0]} & keep);
    // Scatter-gather: table base plus 8-byte entry index from page number.
    wire [33:0] sg_keep = {12'h000, cfg.mask, 10'h3ff};
    wire [33:0] sg_idx = {12'h000, req.addr[31:13], 3'h0} & sg_keep;
    wire [33:0] sg_addr = ({cfg.tbase, 20'h0_0000} & ~sg_keep) | sg_idx;
    assign maddr = cfg.sg ? sg_addr : dir_addr;
endmodule : ptw_win_cmp

// File: verif/ptw_pci_master.sv
// Behavioural PCI master that presents one memory address per request.
// Assumes the bench raises go for one cycle with the address to present.
`timescale 1ns/1ns
module ptw_pci_master (
    input wire aclk,
    input wire go,
    input wire [63:0] addr,
    output ptw_pkg::ptw_req_t pci_req
);
    logic [63:0] last_ff = 64'h0;
    logic dac_sel;
    // A dual-address cycle is used only when the upper half is nonzero.
    assign dac_sel = |addr[63:32];
    // Between requests the address lines show the inverse of the last address.
    assign pci_req = go ? {1'b1, dac_sel, addr} : {1'b0, 1'b0, ~last_ff};
    always_ff @(posedge aclk) begin
        if (go) begin
            last_ff <= addr;
        end
    end
endmodule : ptw_pci_master

// File: verif/ptw_decode_tb_top.sv
// Self-checking bench for the PCI target window decoder.
// Assumes the design package and the master model are compiled first.
`timescale 1ns/1ns
module ptw_decode_tb_top;
    logic aclk, aresetn, awvalid, wvalid, arvalid, go;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [63:0] paddr;
    ptw_pkg::ptw_req_t pci_req;
    ptw_pkg::ptw_rsp_t pci_rsp;
    int err_total, compares, n_claim;
    localparam logic [31:0] SGA = 32'h8765_4321;
    ptw_decode DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pci_req(pci_req), .pci_rsp(pci_rsp));
    ptw_pci_master u_master (.aclk(aclk), .go(go), .addr(paddr), .pci_req(pci_req));
    task report_and_stop;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task chk_w(input string what, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, e, s);
        end
    endtask : chk_w
    task chk_r(input ptw_pkg::ptw_rsp_t e, input ptw_pkg::ptw_rsp_t s);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("FAIL pci_rsp expected %h seen %h", e, s);
        end
    endtask : chk_r
    task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk_w("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : axi_wr
    task axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk_w("rdata", ed, rdata);
        chk_w("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : axi_rd
    // The answer stands for the one cycle after the edge that took the address.
    task probe(input logic [63:0] a, input ptw_pkg::ptw_rsp_t e);
        go <= 1'b1;
        paddr <= a;
        @(posedge aclk);
        go <= 1'b0;
        @(negedge aclk);
        chk_r(e, pci_rsp);
        if (e.claim) n_claim++;
        @(posedge aclk);
    endtask : probe
    task t_reset;
        axi_rd(12'h000, 32'h0, 2'h0);
        axi_rd(12'h040, 32'h0, 2'h0);
        axi_rd(12'h080, 32'h0, 2'h2);
        axi_wr(12'h080, 32'h1, 2'h2);
        $display("test reset done");
    endtask : t_reset
    task t_direct;
        axi_wr(12'h000, 32'h1000_0000, 2'h0);
        axi_wr(12'h004, 32'h0, 2'h0);
        axi_wr(12'h008, 32'h0a94_0000, 2'h0);
        probe(64'h1001_2344, 39'h0);
        axi_wr(12'h000, 32'h1000_0001, 2'h0);
        probe(64'h1001_2344, {1'b1, 1'b0, 3'h0, 14'h2a5, 20'h12344});
        probe(64'h1010_0000, 39'h0);
        axi_wr(12'h010, 32'h2000_0001, 2'h0);
        axi_wr(12'h014, 32'h00f0_0000, 2'h0);
        axi_wr(12'h018, 32'h4000_0000, 2'h0);
        probe(64'h20ab_cdef, {1'b1, 1'b0, 3'h1, 10'h100, 24'habcdef});
        probe(64'h20ff_fffc, {1'b1, 1'b0, 3'h1, 10'h100, 24'hff_fffc});
        probe(64'h2100_0000, 39'h0);
        $display("test direct done");
    endtask : t_direct
    task t_sg4g;
        axi_wr(12'h000, 32'h1000_0000, 2'h0);
        axi_wr(12'h010, 32'h2000_0000, 2'h0);
        axi_wr(12'h020, 32'h0000_0003, 2'h0);
        axi_wr(12'h024, 32'hfff0_0000, 2'h0);
        axi_wr(12'h028, 32'h0a94_0000, 2'h0);
        probe({32'h0, SGA}, {1'b1, 1'b1, 3'h2, 12'h0a9, SGA[31:13], 3'h0});
        axi_wr(12'h020, 32'h0, 2'h0);
        $display("test sg done");
    endtask : t_sg4g
    task t_dac;
        axi_wr(12'h030, 32'h3000_0005, 2'h0);
        axi_wr(12'h034, 32'h0, 2'h0);
        axi_wr(12'h038, 32'h0a94_0000, 2'h0);
        axi_wr(12'h03c, 32'h0000_005a, 2'h0);
        axi_rd(12'h03c, 32'h0000_005a, 2'h0);
        probe(64'h0000_005a_3000_1230, {1'b1, 1'b0, 3'h3, 14'h2a5, 20'h01230});
        probe(64'h0100_005a_3000_1230, 39'h0);
        probe(64'h0000_005b_3000_1230, 39'h0);
        probe(64'h0000_005a_3010_1230, 39'h0);
        probe(64'h3000_1230, {1'b1, 1'b0, 3'h3, 14'h2a5, 20'h01230});
        probe(64'h0000_0002_1234_5678, 39'h0);
        axi_wr(12'h040, 32'h1, 2'h0);
        probe(64'h0000_0002_1234_5678, {1'b1, 1'b0, 3'h4, 34'h2_1234_5678});
        $display("test dac done");
    endtask : t_dac
    task t_status;
        axi_rd(12'h044, n_claim, 2'h0);
        $display("test status done");
    endtask : t_status
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #100000;
        err_total++;
        $display("FAIL watchdog expected finish seen timeout");
        report_and_stop;
    end
    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        go = 1'b0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        paddr = 64'h0;
        err_total = 0;
        compares = 0;
        n_claim = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_direct;
        t_sg4g;
        t_dac;
        t_status;
        report_and_stop;
    end
endmodule : ptw_decode_tb_top
